// ===== logic/bgp_pkg.sv
// Constants, field layouts and carrier types of the byte port
// Overview of operation
// R01: Eight-bit port; each bit's direction set individually by the direction register.
// R02: Data writes load a buffer; pins update only on the selected timing edge.
// R03: Each nibble has its own timing select field.
// R04: Select codes: 00 clock/2, 01 timer A1, 10 timer B1, 11 timer B2.
// R05: Without other selection, outputs update on peripheral clock divided by two.
// R06: Each output bit may be open-drain or actively driven.
// R07: Drive mode bit 0 drives high and low; 1 makes it open-drain.
// R08: Upper four bits in alternate mode carry pulse channels, bit 7 channel three.
// R09: Function bit 0 gives plain port use; 1 selects the alternate function.
// R10: Quadrature decoder, when enabled, takes its inputs from input pins.
// R11: Clocked serial ports use bit 1 (port C) and bit 0 (port D) as clocks.
// R12: Internal serial clock forces its port bit to an output carrying it.
// R13: Four port lines also serve as input-capture inputs.
// R14: Reset clears direction so all pins are inputs; alternate functions disabled.
// R15: Reset clears timing select bits 0, 1, 4 and 5.
// R16: Other registers keep undefined contents across reset.
// R17: Output bits read back their output value; input writes wait for output mode.
// R18: Data register read returns the present state of all eight pins; the code reads output bits from their drive value.
// R19: The port raises no interrupt requests.
// R20: Software sets direction, then timing source, then alternate functions.
// R21: Timer rising edges are found on mclk; transfer happens the cycle after.
package bgp_pkg;
    localparam int DW = 8;
    localparam int AW = 8;
    localparam int NIB = 4;
    localparam int TSEL_W = 2;

    localparam logic [AW-1:0] ADDR_PORT_DATA = 8'h38;
    localparam logic [AW-1:0] ADDR_TIMING_SEL = 8'h3c;
    localparam logic [AW-1:0] ADDR_ALT_FUNC = 8'h3d;
    localparam logic [AW-1:0] ADDR_DRIVE_MODE = 8'h3e;
    localparam logic [AW-1:0] ADDR_DIRECTION = 8'h3f;

    localparam int TSEL_LO_LSB = 0;
    localparam int TSEL_HI_LSB = 4;

    localparam logic [TSEL_W-1:0] TS_PCLK2 = 2'h0;
    localparam logic [TSEL_W-1:0] TS_A1 = 2'h1;
    localparam logic [TSEL_W-1:0] TS_B1 = 2'h2;
    localparam logic [TSEL_W-1:0] TS_B2 = 2'h3;

    localparam logic [DW-1:0] DIR_RST = 8'h00;
    localparam logic [TSEL_W-1:0] TSEL_RST = 2'h0;
    localparam logic [DW-1:0] AFN_RST = 8'h00;
    localparam logic [DW-1:0] OUT_RST = 8'h00;
    localparam logic [DW-1:0] OE_N_RST = 8'hff;
    localparam logic [DW-1:0] RDATA_RST = 8'h00;
    localparam logic [DW-1:0] RDATA_IDLE = 8'h00;

    localparam int PIN_SER_C = 1;
    localparam int PIN_SER_D = 0;
    localparam int TMR_A1 = 0;
    localparam int TMR_B1 = 1;
    localparam int TMR_B2 = 2;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } bgp_bus_s;

    typedef struct packed {
        logic [DW-1:0] o;
        logic [DW-1:0] oe_n;
    } bgp_pins_s;

    typedef struct packed {
        logic two_phase_a;
        logic two_phase_b;
        logic one_phase_a;
        logic one_phase_b;
    } bgp_quad_s;
endpackage : bgp_pkg

// ===== logic/bgp_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bgp_sync3 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Asynchronous input and filtered result
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    if (W < 1) begin : g_chk
        $error("bgp_sync3: W must be at least 1");
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit moves only once the last two stages agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
        end
    end
endmodule : bgp_sync3

// ===== logic/bgp_port.sv
// Byte-wide port with timed output buffers and alternate pin functions
`timescale 1ns/1ps
module bgp_port #(
    parameter int WIDTH = 8
) (
    // Clock, reset and clock enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire bgp_pkg::bgp_bus_s bus,
    output logic [7:0] reg_rdata,
    // Timer outputs, same clock domain
    input wire logic tmr_a1,
    input wire logic tmr_b1,
    input wire logic tmr_b2,
    // Pulse-width channels, bit 3 is channel three
    input wire logic [3:0] pulse_chan,
    // Serial port C clock
    input wire logic serial_c_clocked,
    input wire logic serial_c_int_clk,
    input wire logic serial_c_clock_drive,
    output logic serial_c_clock,
    // Serial port D clock
    input wire logic serial_d_clocked,
    input wire logic serial_d_int_clk,
    input wire logic serial_d_clock_drive,
    output logic serial_d_clock,
    // Quadrature decoder
    input wire logic quad_en,
    input wire logic quad_upper,
    output bgp_pkg::bgp_quad_s quad_phase,
    // Input capture
    output logic [3:0] capture_in,
    // Pins
    input wire logic [7:0] pin_in,
    output bgp_pkg::bgp_pins_s pins
);
    logic [7:0] dir_q;
    logic [7:0] buf_q;
    logic [7:0] out_q;
    logic [7:0] afn_q;
    logic [7:0] drv_q;
    logic [1:0] tsel_lo_q;
    logic [1:0] tsel_hi_q;
    logic div_q;
    logic [2:0] tmr_now;
    logic [2:0] tmr_prev_q;
    logic [2:0] rise_q;
    logic [7:0] pin_s;
    logic tick_lo;
    logic tick_hi;
    logic [7:0] drive_val;
    logic [7:0] drive_en;
    logic [7:0] rd_val;
    logic [3:0] quad_nib;
    logic wr_data;
    logic wr_tsel;
    logic wr_afn;
    logic wr_drv;
    logic wr_dir;
    logic rd_data;
    logic buf_ok_q;

    if (WIDTH != bgp_pkg::DW) begin : g_chk
        $error("bgp_port: pin mapping is fixed to eight bits");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Timing source of one nibble
    function automatic logic sel_tick(input logic [1:0] sel, input logic pclk2,
                                      input logic [2:0] rise);
        logic t;
        t = 1'b0;
        case (sel)
            bgp_pkg::TS_PCLK2: t = pclk2;
            bgp_pkg::TS_A1: t = rise[bgp_pkg::TMR_A1];
            bgp_pkg::TS_B1: t = rise[bgp_pkg::TMR_B1];
            bgp_pkg::TS_B2: t = rise[bgp_pkg::TMR_B2];
            default: t = 1'b0;
        endcase
        sel_tick = t;
    endfunction : sel_tick

    // Address decode
    assign wr_data = bus.wr && hit(bus.addr, bgp_pkg::ADDR_PORT_DATA);
    assign wr_tsel = bus.wr && hit(bus.addr, bgp_pkg::ADDR_TIMING_SEL);
    assign wr_afn = bus.wr && hit(bus.addr, bgp_pkg::ADDR_ALT_FUNC);
    assign wr_drv = bus.wr && hit(bus.addr, bgp_pkg::ADDR_DRIVE_MODE);
    assign wr_dir = bus.wr && hit(bus.addr, bgp_pkg::ADDR_DIRECTION);
    assign rd_data = bus.rd && hit(bus.addr, bgp_pkg::ADDR_PORT_DATA);

    // Pins come from outside the clock domain
    bgp_sync3 #(
        .W(WIDTH)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .d(pin_in),
        .q(pin_s)
    );

    // Direction register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dir_q <= bgp_pkg::DIR_RST; // R14
        end else if (ce && wr_dir) begin
            dir_q <= bus.wdata; // R01
        end
    end

    // Timing select; bits 7:6 and 3:2 are not stored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tsel_lo_q <= bgp_pkg::TSEL_RST; // R15
            tsel_hi_q <= bgp_pkg::TSEL_RST; // R05
        end else if (ce && wr_tsel) begin
            tsel_lo_q <= bus.wdata[bgp_pkg::TSEL_LO_LSB +: bgp_pkg::TSEL_W]; // R03
            tsel_hi_q <= bus.wdata[bgp_pkg::TSEL_HI_LSB +: bgp_pkg::TSEL_W]; // R04
        end
    end

    // Alternate function; cleared so no pin leaves plain use at reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            afn_q <= bgp_pkg::AFN_RST; // R14
        end else if (ce && wr_afn) begin
            afn_q <= bus.wdata; // R09
        end
    end

    // Drive mode and preload buffer carry no reset
    always_ff @(posedge mclk) begin
        if (ce && wr_drv) begin
            drv_q <= bus.wdata; // R16
        end
    end

    always_ff @(posedge mclk) begin
        if (ce && wr_data) begin
            buf_q <= bus.wdata; // R02
        end
    end

    // Buffer is unknown until first written; checks wait for that
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_ok_q <= 1'b0;
        end else if (ce && wr_data) begin
            buf_ok_q <= 1'b1;
        end
    end

    // Peripheral clock divided by two
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_q <= 1'b0;
        end else if (ce) begin
            div_q <= ~div_q;
        end
    end

    // Timer edges; one cycle of latency keeps the transfer registered
    assign tmr_now = {tmr_b2, tmr_b1, tmr_a1};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tmr_prev_q <= 3'h0;
            rise_q <= 3'h0;
        end else if (ce) begin
            tmr_prev_q <= tmr_now;
            rise_q <= tmr_now & ~tmr_prev_q; // R21
        end
    end

    assign tick_lo = sel_tick(tsel_lo_q, div_q, rise_q); // R03
    assign tick_hi = sel_tick(tsel_hi_q, div_q, rise_q); // R03

    // Output register, one transfer per nibble
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_q <= bgp_pkg::OUT_RST;
        end else if (ce) begin
            if (tick_lo) begin
                out_q[3:0] <= buf_q[3:0]; // R02
            end
            if (tick_hi) begin
                out_q[7:4] <= buf_q[7:4]; // R02
            end
        end
    end

    // Pin source and enable before drive mode
    always_comb begin
        drive_val = out_q;
        drive_en = dir_q; // R17
        for (int i = bgp_pkg::NIB; i < bgp_pkg::DW; i++) begin
            if (afn_q[i]) begin
                drive_val[i] = pulse_chan[i - bgp_pkg::NIB]; // R08
            end
        end
        if (serial_c_clocked && serial_c_int_clk) begin
            drive_val[bgp_pkg::PIN_SER_C] = serial_c_clock_drive; // R11
            drive_en[bgp_pkg::PIN_SER_C] = 1'b1; // R12
        end
        if (serial_d_clocked && serial_d_int_clk) begin
            drive_val[bgp_pkg::PIN_SER_D] = serial_d_clock_drive; // R11
            drive_en[bgp_pkg::PIN_SER_D] = 1'b1; // R12
        end
    end

    // Open-drain bits only ever pull low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pins.o <= bgp_pkg::OUT_RST;
            pins.oe_n <= bgp_pkg::OE_N_RST;
        end else if (ce) begin
            pins.o <= drive_val & ~drv_q; // R07
            pins.oe_n <= ~(drive_en & ~(drv_q & drive_val)); // R06
        end
    end

    // Output bits show what is driven, input bits the pin
    assign rd_val = (drive_en & drive_val) | (~drive_en & pin_s); // R18

    // Write-only registers and unmapped addresses read as zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= bgp_pkg::RDATA_RST;
        end else if (ce) begin
            reg_rdata <= rd_data ? rd_val : bgp_pkg::RDATA_IDLE; // R17
        end
    end

    // Quadrature inputs, masked to input bits
    assign quad_nib = quad_upper ? (pin_s[7:4] & ~dir_q[7:4]) : (pin_s[3:0] & ~dir_q[3:0]);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            quad_phase <= '0;
        end else if (ce) begin
            quad_phase <= quad_en ? quad_nib : 4'h0; // R10
        end
    end

    // Received serial clocks and capture lines come straight from synchronised pins
    assign serial_c_clock = pin_s[bgp_pkg::PIN_SER_C]; // R11
    assign serial_d_clock = pin_s[bgp_pkg::PIN_SER_D]; // R11
    assign capture_in = {pin_s[7], pin_s[5], pin_s[3], pin_s[1]}; // R13

    // No interrupt output exists at all R19

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_lo_xfer;
        ce && buf_ok_q && tick_lo |=> out_q[3:0] == $past(buf_q[3:0]);
    endproperty
    a_lo_xfer: assert property (p_lo_xfer) // R02
        else $error("low nibble did not take buffer on tick");

    property p_hi_hold;
        ce && buf_ok_q && !tick_hi |=> $stable(out_q[7:4]);
    endproperty
    a_hi_hold: assert property (p_hi_hold) // R02
        else $error("high nibble changed without tick");

    property p_hi_xfer;
        ce && buf_ok_q && tick_hi |=> out_q[7:4] == $past(buf_q[7:4]);
    endproperty
    a_hi_xfer: assert property (p_hi_xfer) // R03
        else $error("high nibble did not take buffer on tick");

    property p_quad_off;
        !quad_en |=> quad_phase == 4'h0;
    endproperty
    a_quad_off: assert property (p_quad_off) // R10
        else $error("quadrature inputs seen while disabled");

    property p_pclk_rate;
        ce && tsel_lo_q == bgp_pkg::TS_PCLK2 && !wr_tsel && tick_lo ##1 ce |-> !tick_lo;
    endproperty
    a_pclk_rate: assert property (p_pclk_rate) // R05
        else $error("divided clock ticked twice in a row");

    property p_timer;
        ce && buf_ok_q && rise_q[0] && tsel_hi_q == bgp_pkg::TS_A1
            |=> out_q[7:4] == $past(buf_q[7:4]);
    endproperty
    a_timer: assert property (p_timer) // R04
        else $error("timer A1 edge did not transfer upper nibble");

    property p_rise_delay;
        ce && tmr_a1 && !tmr_prev_q[0] |=> rise_q[0];
    endproperty
    a_rise_delay: assert property (p_rise_delay) // R21
        else $error("timer rising edge not seen one cycle later");

    property p_dir_hiz;
        ce |=> ((~pins.oe_n & ~$past(dir_q)) & 8'hfc) == 8'h00;
    endproperty
    a_dir_hiz: assert property (p_dir_hiz) // R01
        else $error("input bit is being driven");

    property p_open_drain;
        ce |=> (~pins.oe_n & pins.o & $past(drv_q)) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) // R07
        else $error("open-drain bit driven high");

    property p_read;
        ce && rd_data |=> reg_rdata == $past(rd_val);
    endproperty
    a_read: assert property (p_read) // R18
        else $error("read data not pin state one cycle later");

    property p_read_zero;
        ce && !rd_data |=> reg_rdata == 8'h00;
    endproperty
    a_read_zero: assert property (p_read_zero) // R17
        else $error("read data nonzero outside data read");

    property p_force_c;
        ce && serial_c_clocked && serial_c_int_clk && !drv_q[1]
            |=> !pins.oe_n[1] && pins.o[1] == $past(serial_c_clock_drive);
    endproperty
    a_force_c: assert property (p_force_c) // R12
        else $error("serial C clock not forced onto bit 1");
endmodule : bgp_port

// ===== tb/bgp_board.sv
// Board model: pulled-up port lines plus optional external drivers
`timescale 1ns/1ps
module bgp_board (
    // Port side
    input wire bgp_pkg::bgp_pins_s pins,
    // External drivers
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // Resolved lines
    output logic [7:0] pin_in
);
    // Pull-up, so a released open-drain line reads high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pins.oe_n[i])
                pin_in[i] = pins.o[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule : bgp_board

// ===== tb/bgp_port_tb.sv
// Self-checking bench for the byte port
`timescale 1ns/1ps
module bgp_port_tb;
    localparam logic [7:0] PD = bgp_pkg::ADDR_PORT_DATA;
    localparam logic [7:0] TS = bgp_pkg::ADDR_TIMING_SEL;
    localparam logic [7:0] AF = bgp_pkg::ADDR_ALT_FUNC;
    localparam logic [7:0] DM = bgp_pkg::ADDR_DRIVE_MODE;
    localparam logic [7:0] DR = bgp_pkg::ADDR_DIRECTION;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    bgp_pkg::bgp_bus_s bus = '0;
    logic [7:0] reg_rdata;
    logic [2:0] tmr = 3'h0;
    logic [3:0] pulse_chan = 4'h0;
    // Index is the pin: 1 for port C, 0 for port D
    logic [1:0] s_on = 2'h0;
    logic [1:0] s_int = 2'h0;
    logic [1:0] s_drv = 2'h0;
    logic [1:0] s_clk;
    logic quad_en = 1'b0;
    logic quad_upper = 1'b0;
    bgp_pkg::bgp_quad_s quad_phase;
    logic [3:0] capture_in;
    logic [7:0] pin_in;
    logic [7:0] ext_val = 8'ha6;
    logic [7:0] ext_en = 8'hff;
    bgp_pkg::bgp_pins_s pins;
    int failures = 0;
    int comparisons = 0;
    logic [7:0] rv;
    logic [3:0] up;

    always #50 mclk = ~mclk;

    bgp_port DUT (.mclk(mclk), .rst(rst), .ce(ce), .bus(bus), .reg_rdata(reg_rdata),
        .tmr_a1(tmr[0]), .tmr_b1(tmr[1]), .tmr_b2(tmr[2]), .pulse_chan(pulse_chan),
        .serial_c_clocked(s_on[1]), .serial_c_int_clk(s_int[1]),
        .serial_c_clock_drive(s_drv[1]), .serial_c_clock(s_clk[1]),
        .serial_d_clocked(s_on[0]), .serial_d_int_clk(s_int[0]),
        .serial_d_clock_drive(s_drv[0]), .serial_d_clock(s_clk[0]),
        .quad_en(quad_en), .quad_upper(quad_upper), .quad_phase(quad_phase),
        .capture_in(capture_in), .pin_in(pin_in), .pins(pins));

    bgp_board board (.pins(pins), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Bounded wait; a miss ends the run
    task automatic wait_o(input logic [7:0] exp);
        int n;
        n = 0;
        while (pins.o !== exp && n < 10) begin
            @(posedge mclk);
            #1 n++;
        end
        chk("pins.o", exp, pins.o);
        if (n == 10)
            close_out();
    endtask : wait_o

    task automatic pulse(input int i);
        @(posedge mclk);
        tmr[i] <= 1'b1;
        cyc(2);
        tmr[i] <= 1'b0;
    endtask : pulse

    task automatic t_reset();
        #1 chk("oe_n", 8'hff, pins.oe_n);
        cyc(4);
        rd(PD, rv);
        chk("pin read", 8'ha6, rv);
        $display("test reset done");
    endtask : t_reset

    // No timing select written, so the reset default must pace outputs
    task automatic t_default();
        ext_en <= 8'h00;
        wr(DM, 8'h00);
        wr(PD, 8'h00);
        cyc(4);
        wr(DR, 8'hff);
        wr(DM, 8'h00);
        wr(PD, 8'h3c);
        #1 chk("pins before tick", 8'h00, pins.o);
        wait_o(8'h3c);
        chk("oe_n", 8'h00, pins.oe_n);
        $display("test default timing done");
    endtask : t_default

    task automatic t_timer();
        for (int c = 1; c < 4; c++) begin
            up = pins.o[7:4];
            wr(TS, {2'h0, c[1:0], 4'h0});
            wr(PD, 8'h11 * c[7:0]);
            wait_o({up, c[3:0]});
            for (int o = 0; o < 3; o++)
                if (o != c - 1)
                    pulse(o);
            cyc(4);
            #1 chk("upper held", {up, c[3:0]}, pins.o);
            pulse(c - 1);
            #1 chk("pins at edge+2", {up, c[3:0]}, pins.o);
            @(posedge mclk);
            #1 chk("pins at edge+3", 8'h11 * c[7:0], pins.o);
        end
        $display("test timer timing done");
    endtask : t_timer

    task automatic t_drive();
        wr(TS, 8'h00);
        wr(DM, 8'h0f);
        wr(PD, 8'h55);
        wait_o(8'h50);
        chk("oe_n", 8'h05, pins.oe_n);
        rd(PD, rv);
        cyc(6);
        rd(PD, rv);
        chk("read", 8'h55, rv);
        $display("test drive mode done");
    endtask : t_drive

    task automatic t_held();
        wr(DM, 8'h00);
        wr(DR, 8'h0f);
        ext_val <= 8'h90;
        ext_en <= 8'hf0;
        wr(PD, 8'ha5);
        cyc(8);
        chk("oe_n", 8'hf0, pins.oe_n);
        rd(PD, rv);
        chk("mixed read", 8'h95, rv);
        ext_en <= 8'h00;
        wr(DR, 8'hff);
        cyc(3);
        chk("oe_n", 8'h00, pins.oe_n);
        wait_o(8'ha5);
        $display("test held data done");
    endtask : t_held

    task automatic t_alt();
        pulse_chan <= 4'h9;
        wr(AF, 8'hf0);
        wait_o(8'h95);
        pulse_chan <= 4'h6;
        wait_o(8'h65);
        wr(AF, 8'h00);
        wait_o(8'ha5);
        $display("test pulse channels done");
    endtask : t_alt

    task automatic t_serial();
        wr(DR, 8'h00);
        for (int b = 0; b < 2; b++) begin
            s_on[b] <= 1'b1;
            s_int[b] <= 1'b1;
            s_drv[b] <= 1'b1;
            cyc(4);
            chk("forced oe_n", ~(8'h01 << b), pins.oe_n);
            chk("clock high", 8'h01, {7'h00, pins.o[b]});
            s_drv[b] <= 1'b0;
            cyc(4);
            chk("clock low", 8'h00, {7'h00, pins.o[b]});
            s_int[b] <= 1'b0;
            ext_val[b] <= 1'b1;
            ext_en[b] <= 1'b1;
            cyc(6);
            chk("released", 8'hff, pins.oe_n);
            chk("ext clock", 8'h01, {7'h00, s_clk[b]});
            ext_val[b] <= 1'b0;
            cyc(6);
            chk("ext clock", 8'h00, {7'h00, s_clk[b]});
            s_on[b] <= 1'b0;
            ext_en[b] <= 1'b0;
        end
        $display("test serial clocks done");
    endtask : t_serial

    task automatic t_quad();
        ext_val <= 8'ha6;
        ext_en <= 8'hff;
        quad_en <= 1'b1;
        cyc(6);
        chk("quad low", 8'h06, {4'h0, quad_phase});
        chk("capture", 8'h0d, {4'h0, capture_in});
        quad_upper <= 1'b1;
        cyc(3);
        chk("quad high", 8'h0a, {4'h0, quad_phase});
        quad_upper <= 1'b0;
        ext_en <= 8'hf0;
        wr(DR, 8'h0f);
        cyc(6);
        chk("quad outputs masked", 8'h00, {4'h0, quad_phase});
        quad_en <= 1'b0;
        cyc(3);
        chk("quad off", 8'h00, {4'h0, quad_phase});
        $display("test quad and capture done");
    endtask : t_quad

    task automatic t_regs();
        rd(TS, rv);
        chk("write-only read", 8'h00, rv);
        rd(8'h20, rv);
        chk("unmapped read", 8'h00, rv);
        ce <= 1'b0;
        wr(PD, 8'h0f);
        ce <= 1'b1;
        cyc(6);
        chk("frozen pins", 8'h05, pins.o[7:0] & 8'h0f);
        $display("test register map done");
    endtask : t_regs

    initial begin
        cyc(5);
        rst <= 1'b0;
        t_reset();
        t_default();
        t_timer();
        t_drive();
        t_held();
        t_alt();
        t_serial();
        t_quad();
        t_regs();
        close_out();
    end

    initial begin
        cyc(20000);
        failures++;
        close_out();
    end
endmodule : bgp_port_tb
